// [ssp_pkg.sv]
// Constants shared by the serial port design
package ssp_pkg;

  // ------------------------------------------------------------------
  // Register offsets on the plain register port
  // ------------------------------------------------------------------
  localparam logic [1:0] SSP_OFS_CTRL   = 2'h0;
  localparam logic [1:0] SSP_OFS_STATUS = 2'h1;
  localparam logic [1:0] SSP_OFS_DATA   = 2'h2;

  // ------------------------------------------------------------------
  // Control register field positions
  // ------------------------------------------------------------------
  localparam int SSP_CTRL_IRQ_EN  = 7;
  localparam int SSP_CTRL_PORT_EN = 6;
  localparam int SSP_CTRL_LSB_1ST = 5;
  localparam int SSP_CTRL_MASTER  = 4;
  localparam int SSP_CTRL_CLOCK_POLARITY    = 3;
  localparam int SSP_CTRL_CLOCK_PHASE    = 2;
  localparam int SSP_CTRL_RATE_HI = 1;
  localparam int SSP_CTRL_RATE_LO = 0;

  // ------------------------------------------------------------------
  // Status register field positions
  // ------------------------------------------------------------------
  localparam int SSP_STAT_DONE    = 7;
  localparam int SSP_STAT_WRITE_COLLISION_FLAG    = 6;
  localparam int SSP_STAT_DBL     = 0;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] SSP_CTRL_RST   = 8'h00;
  localparam logic [7:0] SSP_DATA_RST   = 8'h00;

  // ------------------------------------------------------------------
  // Frame and clock generator figures
  // ------------------------------------------------------------------
  localparam logic [3:0] SSP_LAST_BIT   = 4'h7;
  localparam logic [4:0] SSP_LAST_EDGE  = 5'h0F;
  // Half SCK periods in system clocks for /2 /4 /8 /16 /32 /64 /128
  localparam logic [6:0] SSP_HALF_DIV2   = 7'h01;
  localparam logic [6:0] SSP_HALF_DIV4   = 7'h02;
  localparam logic [6:0] SSP_HALF_DIV8   = 7'h04;
  localparam logic [6:0] SSP_HALF_DIV16  = 7'h08;
  localparam logic [6:0] SSP_HALF_DIV32  = 7'h10;
  localparam logic [6:0] SSP_HALF_DIV64  = 7'h20;
  localparam logic [6:0] SSP_HALF_DIV128 = 7'h40;

  // ------------------------------------------------------------------
  // Master sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00,
    SSP_RUN  = 2'b01,
    SSP_FIN  = 2'b10
  } ssp_state_t;

endpackage

// [ssp_core.sv]
// Byte-wide master/slave synchronous serial port with register port
//
// Functional notes
// - Slave: select input; low activates, MISO per direction
// - Slave with select high captures nothing
// - Select high resets slave shift and counter
// - Master with select output: plain general pin
// - Master, select input low: drop to slave
// - Forced drop to slave sets done flag
// - Stays slave until software sets master again
// - Bit 7 enables interrupt with done flag
// - Bit 6 enables port; nothing moves otherwise
// - Bit 5 one sends LSB first
// - Bit 4 selects master, zero slave
// - Bit 3 sets SCK idle level
// - Bit 2 picks sample edge leading or trailing
// - Master SCK divider from two rate bits and double-rate bit
// - Rate bits ignored in slave mode
// - Done flag: set on end, cleared two ways
// - Data write while busy sets collision flag
// - Status bits 5..1 read zero
// - Status bit 0 doubles master SCK rate
// - Data write starts; data read gives buffer
// - Shift and capture on opposite SCK edges
// - Master stops after eight bits, awaits write
// - Receive buffer holds until next byte complete
// - Enabled port forces pin directions by mode
module ssp_core
  import ssp_pkg::*;
#(
  parameter int WORD_BITS = 8
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic [1:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  input  wire logic       globalIrqEn,
  input  wire logic       irqAck,
  output logic            xferIrq,
  input  wire logic       dirMosi,
  input  wire logic       dirMiso,
  input  wire logic       dirSck,
  input  wire logic       dirSel,
  input  wire logic       gpioMosi,
  input  wire logic       gpioMiso,
  input  wire logic       gpioSck,
  input  wire logic       gpioSel,
  input  wire logic       mosiIn,
  output logic            mosiOut,
  output logic            mosiDriveN,
  input  wire logic       misoIn,
  output logic            misoOut,
  output logic            misoDriveN,
  input  wire logic       sckIn,
  output logic            sckOut,
  output logic            sckDriveN,
  input  wire logic       selIn,
  output logic            selOut,
  output logic            selDriveN
);

  // ------------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------------
  // Register layout and counters are built for byte frames only
  if (WORD_BITS != 8) begin : gBadWidth
    $error("ssp_core supports WORD_BITS of 8 only");
  end

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  // First bit to go out of a byte for the chosen order
  function automatic logic headBit(input logic [7:0] b, input logic lsb);
    headBit = lsb ? b[0] : b[7];
  endfunction

  // Shift one received bit in, pushing the sent bit out
  function automatic logic [7:0] shiftIn(input logic [7:0] b,
                                         input logic       lsb,
                                         input logic       bitIn);
    shiftIn = lsb ? {bitIn, b[7:1]} : {b[6:0], bitIn};
  endfunction

  // Half SCK period from double-rate and the two rate bits
  function automatic logic [6:0] halfPeriod(input logic       dbl,
                                            input logic [1:0] rate);
    unique case ({dbl, rate})
      3'b000:  halfPeriod = SSP_HALF_DIV4;
      3'b001:  halfPeriod = SSP_HALF_DIV16;
      3'b010:  halfPeriod = SSP_HALF_DIV64;
      3'b011:  halfPeriod = SSP_HALF_DIV128;
      3'b100:  halfPeriod = SSP_HALF_DIV2;
      3'b101:  halfPeriod = SSP_HALF_DIV8;
      3'b110:  halfPeriod = SSP_HALF_DIV32;
      default: halfPeriod = SSP_HALF_DIV64;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic       rstSync1_ff, rstSync2_ff, rstN;
  logic       irqEn_ff, portEn_ff, lsbFirst_ff, master_ff;
  logic       clock_polarity_ff, clock_phase_ff, dblRate_ff;
  logic [1:0] rateSel_ff;
  logic       doneFlag_ff, wcolFlag_ff, statArmed_ff, donePend_ff;
  logic [7:0] txByte_ff, shift_ff, rxBuf_ff, regRdData_ff;
  logic       outBit_ff, sckInt_ff, sckPrev_ff, xferIrq_ff;
  logic [3:0] bitCnt_ff;
  logic [4:0] edgeCnt_ff;
  logic [6:0] divCnt_ff;
  ssp_state_t state_ff, nxt_state;
  logic       wrCtrl, wrStat, wrData, dataAccess, flagClr;
  logic       modeFault, slaveActive, slaveReset, busy, accept;
  logic       mEdge, mSample, mSetup, sEdge, sLead, sSample, sSetup;
  logic       sampleEv, setupEv, inBit, slaveDone, masterFin, mSmpD_ff;
  logic [7:0] nxt_regRdData;
  logic       nxt_mosiOut, nxt_mosiDriveN, nxt_misoOut, nxt_misoDriveN;
  logic       nxt_sckOut, nxt_sckDriveN, nxt_selOut, nxt_selDriveN;
  logic       mosiOut_ff, mosiDriveN_ff, misoOut_ff, misoDriveN_ff;
  logic       sckOut_ff, sckDriveN_ff, selOut_ff, selDriveN_ff;

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  // Two stages so the release never lands mid-setup of any flop
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end
  assign rstN = rstSync2_ff;

  // ------------------------------------------------------------------
  // Decode and event terms
  // ------------------------------------------------------------------
  assign wrCtrl     = regWr && (regAddr == SSP_OFS_CTRL);
  assign wrStat     = regWr && (regAddr == SSP_OFS_STATUS);
  assign wrData     = regWr && (regAddr == SSP_OFS_DATA);
  assign dataAccess = (regWr || regRd) && (regAddr == SSP_OFS_DATA);
  assign flagClr    = statArmed_ff && dataAccess;
  // Another master pulls select low while we master
  assign modeFault  = portEn_ff && master_ff && !dirSel && !selIn;
  assign slaveActive = portEn_ff && !master_ff && !selIn;
  assign slaveReset = portEn_ff && !master_ff && selIn
                      && (bitCnt_ff != 4'h0);
  assign busy       = master_ff ? (state_ff != SSP_IDLE)
                                : (slaveActive && (bitCnt_ff != 4'h0));
  assign accept     = wrData && !busy;

  // Master edges come from the divider; leading edges are even ones
  assign mEdge   = (state_ff == SSP_RUN) && (divCnt_ff == 7'h00);
  assign mSample = mEdge && (edgeCnt_ff[0] == clock_phase_ff);
  assign mSetup  = mEdge && (edgeCnt_ff[0] != clock_phase_ff);
  // Slave edges: compare sampled SCK against its last value
  assign sEdge   = slaveActive && (sckIn != sckPrev_ff);
  assign sLead   = (sckIn != clock_polarity_ff);
  assign sSample = sEdge && (sLead != clock_phase_ff);
  assign sSetup  = sEdge && (sLead == clock_phase_ff);
  assign sampleEv = mSmpD_ff || sSample;
  assign setupEv  = mSetup || sSetup;
  assign inBit    = master_ff ? misoIn : mosiIn;
  assign slaveDone = sSample && (bitCnt_ff == SSP_LAST_BIT);
  assign masterFin = (state_ff == SSP_FIN);

  // ------------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------------
  // Hardware clear of master wins over a same-cycle software write
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      irqEn_ff    <= SSP_CTRL_RST[SSP_CTRL_IRQ_EN];
      portEn_ff   <= SSP_CTRL_RST[SSP_CTRL_PORT_EN];
      lsbFirst_ff <= SSP_CTRL_RST[SSP_CTRL_LSB_1ST];
      master_ff   <= SSP_CTRL_RST[SSP_CTRL_MASTER];
      clock_polarity_ff     <= SSP_CTRL_RST[SSP_CTRL_CLOCK_POLARITY];
      clock_phase_ff     <= SSP_CTRL_RST[SSP_CTRL_CLOCK_PHASE];
      rateSel_ff  <= SSP_CTRL_RST[SSP_CTRL_RATE_HI:SSP_CTRL_RATE_LO];
    end else begin
      if (wrCtrl) begin
        irqEn_ff    <= regWrData[SSP_CTRL_IRQ_EN];
        portEn_ff   <= regWrData[SSP_CTRL_PORT_EN];
        lsbFirst_ff <= regWrData[SSP_CTRL_LSB_1ST];
        master_ff   <= regWrData[SSP_CTRL_MASTER];
        clock_polarity_ff     <= regWrData[SSP_CTRL_CLOCK_POLARITY];
        clock_phase_ff     <= regWrData[SSP_CTRL_CLOCK_PHASE];
        rateSel_ff  <= regWrData[SSP_CTRL_RATE_HI:SSP_CTRL_RATE_LO];
      end
      if (modeFault) begin
        master_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------------
  // A new event in the clearing cycle survives: set beats clear
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      doneFlag_ff  <= 1'b0;
      wcolFlag_ff  <= 1'b0;
      statArmed_ff <= 1'b0;
      dblRate_ff   <= 1'b0;
    end else begin
      if (wrStat) begin
        dblRate_ff <= regWrData[SSP_STAT_DBL];
      end
      if (regRd && (regAddr == SSP_OFS_STATUS)) begin
        statArmed_ff <= doneFlag_ff || wcolFlag_ff;
      end else if (dataAccess) begin
        statArmed_ff <= 1'b0;
      end
      if (masterFin || donePend_ff || modeFault) begin
        doneFlag_ff <= 1'b1;
      end else if (flagClr || irqAck) begin
        doneFlag_ff <= 1'b0;
      end
      if (wrData && busy) begin
        wcolFlag_ff <= 1'b1;
      end else if (flagClr) begin
        wcolFlag_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Master sequencer
  // ------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SSP_IDLE: if (accept && portEn_ff && master_ff && !modeFault) begin
        nxt_state = SSP_RUN;
      end
      SSP_RUN: if (mEdge && (edgeCnt_ff == SSP_LAST_EDGE)) begin
        nxt_state = SSP_FIN;
      end
      SSP_FIN: nxt_state = SSP_IDLE;
      default: nxt_state = SSP_IDLE;
    endcase
    // Losing the bus or the enable aborts at once
    if (modeFault || !portEn_ff) begin
      nxt_state = SSP_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      state_ff <= SSP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------------
  // Master clock divider and SCK level
  // ------------------------------------------------------------------
  // Rate bits only read when the divider loads, i.e. outside SSP_RUN and at each master edge
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      divCnt_ff  <= 7'h00;
      edgeCnt_ff <= 5'h00;
      sckInt_ff  <= 1'b0;
    end else if (state_ff != SSP_RUN) begin
      divCnt_ff  <= halfPeriod(dblRate_ff, rateSel_ff) - 7'h01;
      edgeCnt_ff <= 5'h00;
      sckInt_ff  <= clock_polarity_ff;
    end else if (mEdge) begin
      divCnt_ff  <= halfPeriod(dblRate_ff, rateSel_ff) - 7'h01;
      edgeCnt_ff <= edgeCnt_ff + 5'h01;
      sckInt_ff  <= !sckInt_ff;
    end else begin
      divCnt_ff  <= divCnt_ff - 7'h01;
    end
  end

  // ------------------------------------------------------------------
  // Shift register, output bit and bit counter
  // ------------------------------------------------------------------
  // Transmit is single buffered: a busy write is dropped, not queued
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      txByte_ff  <= SSP_DATA_RST;
      shift_ff   <= SSP_DATA_RST;
      outBit_ff  <= 1'b0;
      bitCnt_ff  <= 4'h0;
      sckPrev_ff <= 1'b0;
    end else begin
      sckPrev_ff <= sckIn;
      if (accept) begin
        txByte_ff <= regWrData;
        shift_ff  <= regWrData;
        outBit_ff <= headBit(regWrData, lsbFirst_ff);
        bitCnt_ff <= 4'h0;
      end else if (slaveReset || modeFault || !portEn_ff) begin
        shift_ff  <= txByte_ff;
        outBit_ff <= headBit(txByte_ff, lsbFirst_ff);
        bitCnt_ff <= 4'h0;
      end else begin
        if (sampleEv) begin
          shift_ff  <= shiftIn(shift_ff, lsbFirst_ff, inBit);
          bitCnt_ff <= (bitCnt_ff == SSP_LAST_BIT) ? 4'h0
                                                   : bitCnt_ff + 4'h1;
        end
        if (setupEv) begin
          outBit_ff <= headBit(sampleEv ? shiftIn(shift_ff, lsbFirst_ff,
                               inBit) : shift_ff, lsbFirst_ff);
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Receive buffer
  // ------------------------------------------------------------------
  // Copied one cycle after the last sample so that bit is included
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      donePend_ff <= 1'b0;
      mSmpD_ff    <= 1'b0;
      rxBuf_ff    <= SSP_DATA_RST;
    end else begin
      donePend_ff <= slaveDone && !accept;
      // Master takes MISO when its SCK pin edge shows, a cycle late
      mSmpD_ff    <= mSample && !modeFault && portEn_ff;
      if (masterFin || donePend_ff) begin
        rxBuf_ff <= mSmpD_ff ? shiftIn(shift_ff, lsbFirst_ff, inBit)
                             : shift_ff;
      end
    end
  end

  // ------------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------------
  always_comb begin
    nxt_regRdData = 8'h00;
    unique case (regAddr)
      SSP_OFS_CTRL: nxt_regRdData = {irqEn_ff, portEn_ff, lsbFirst_ff,
                                     master_ff, clock_polarity_ff, clock_phase_ff,
                                     rateSel_ff};
      SSP_OFS_STATUS: nxt_regRdData = {doneFlag_ff, wcolFlag_ff,
                                       5'h00, dblRate_ff};
      SSP_OFS_DATA: nxt_regRdData = rxBuf_ff;
      default: nxt_regRdData = 8'h00;
    endcase
  end

  // Data holds only in the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      regRdData_ff <= 8'h00;
    end else begin
      regRdData_ff <= regRd ? nxt_regRdData : 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt request
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      xferIrq_ff <= 1'b0;
    end else begin
      xferIrq_ff <= irqEn_ff && doneFlag_ff && globalIrqEn;
    end
  end

  // ------------------------------------------------------------------
  // Pin direction overrides
  // ------------------------------------------------------------------
  // Drive enables are active low; user direction one means output
  always_comb begin
    nxt_mosiOut    = gpioMosi;
    nxt_mosiDriveN = !dirMosi;
    nxt_misoOut    = gpioMiso;
    nxt_misoDriveN = !dirMiso;
    nxt_sckOut     = gpioSck;
    nxt_sckDriveN  = !dirSck;
    nxt_selOut     = gpioSel;
    nxt_selDriveN  = !dirSel;
    if (portEn_ff && master_ff) begin
      nxt_mosiOut    = outBit_ff;
      nxt_sckOut     = sckInt_ff;
      nxt_misoDriveN = 1'b1;
    end else if (portEn_ff) begin
      nxt_mosiDriveN = 1'b1;
      nxt_sckDriveN  = 1'b1;
      nxt_selDriveN  = 1'b1;
      if (!selIn) begin
        nxt_misoOut = outBit_ff;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      mosiOut_ff    <= 1'b0;
      mosiDriveN_ff <= 1'b1;
      misoOut_ff    <= 1'b0;
      misoDriveN_ff <= 1'b1;
      sckOut_ff     <= 1'b0;
      sckDriveN_ff  <= 1'b1;
      selOut_ff     <= 1'b0;
      selDriveN_ff  <= 1'b1;
    end else begin
      mosiOut_ff    <= nxt_mosiOut;
      mosiDriveN_ff <= nxt_mosiDriveN;
      misoOut_ff    <= nxt_misoOut;
      misoDriveN_ff <= nxt_misoDriveN;
      sckOut_ff     <= nxt_sckOut;
      sckDriveN_ff  <= nxt_sckDriveN;
      selOut_ff     <= nxt_selOut;
      selDriveN_ff  <= nxt_selDriveN;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign regRdData  = regRdData_ff;
  assign xferIrq    = xferIrq_ff;
  assign mosiOut    = mosiOut_ff;
  assign mosiDriveN = mosiDriveN_ff;
  assign misoOut    = misoOut_ff;
  assign misoDriveN = misoDriveN_ff;
  assign sckOut     = sckOut_ff;
  assign sckDriveN  = sckDriveN_ff;
  assign selOut     = selOut_ff;
  assign selDriveN  = selDriveN_ff;

endmodule

// [ssp_core_checker.sv]
// Concurrent checks on the serial port core pins
module ssp_core_checker
  import ssp_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdData,
  input wire logic       globalIrqEn,
  input wire logic       xferIrq,
  input wire logic       dirMosi,
  input wire logic       dirSel,
  input wire logic       gpioMosi,
  input wire logic       gpioSel,
  input wire logic       selIn,
  input wire logic       mosiOut,
  input wire logic       mosiDriveN,
  input wire logic       misoDriveN,
  input wire logic       sckDriveN,
  input wire logic       selOut,
  input wire logic       selDriveN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctrlCopy_ff;
  logic [2:0] rdy_ff;
  logic       en, ms, sl;
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Control shadow; a forced drop to slave is not mirrored here
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrlCopy_ff <= 8'h00;
      rdy_ff      <= 3'h0;
    end else begin
      rdy_ff <= {rdy_ff[1:0], 1'b1};
      if (regWr && regAddr == SSP_OFS_CTRL)
        ctrlCopy_ff <= regWrData;
    end
  end
  assign en = ctrlCopy_ff[SSP_CTRL_PORT_EN];
  assign ms = en && ctrlCopy_ff[SSP_CTRL_MASTER];
  assign sl = en && !ctrlCopy_ff[SSP_CTRL_MASTER];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence selDrop;
    ms && !dirSel && !selIn;
  endsequence
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  rd_idle_zero_a: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data not zero outside read cycle");
  stat_reserved_a: assert property ($past(regRd && regAddr == SSP_OFS_STATUS)
    |-> regRdData[5:1] == 5'h00) else $error("reserved status bits set");
  irq_gate_a: assert property (xferIrq
    |-> $past(globalIrqEn && ctrlCopy_ff[SSP_CTRL_IRQ_EN]))
    else $error("interrupt without its enables");
  slave_inputs_a: assert property (sl ##1 sl
    |-> sckDriveN && mosiDriveN && selDriveN) else $error("slave drives pin");
  master_miso_a: assert property ($past(ms) && ms |-> misoDriveN)
    else $error("master drives miso");
  gpio_select_a: assert property (ms && dirSel
    |=> selOut == $past(gpioSel) && !selDriveN) else $error("select not gpio");
  disabled_pins_a: assert property (rdy_ff[2] && !en |=>
    mosiOut == $past(gpioMosi) && mosiDriveN == !$past(dirMosi))
    else $error("disabled port does not follow user pins");
  forced_slave_a: assert property (selDrop ##1 !selIn |-> ##[1:3] sckDriveN)
    else $error("master kept sck after select low");
endmodule

bind ssp_core ssp_core_checker ssp_core_checker_i (.*);

// [ssp_slave_model.sv]
// Behavioural far-side serial slave for master transfers
module ssp_slave_model (
  input wire logic       sck,
  input wire logic       selN,
  input wire logic       mosi,
  input wire logic       clock_polarity,
  input wire logic       clock_phase,
  input wire logic       lsb,
  input wire logic [7:0] txByte,
  output logic           miso,
  output logic     [7:0] rxByte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] nSmp = 3'h0;
  logic [2:0] outIdx = 3'h0;
  logic       last = 1'b0;
  // New frame restarts both bit counters
  always @(negedge selN) begin
    nSmp = 3'h0;
    outIdx = 3'h0;
  end
  // Sample and setup on opposite edges, per polarity and phase
  always @(sck) if (!selN) begin
    if ((sck != clock_polarity) ^ clock_phase) begin
      rxByte[lsb ? nSmp : ~nSmp] = mosi;
      nSmp = nSmp + 3'h1;
    end else
      outIdx = nSmp;
  end
  // Released line shows the inverse, so stale data never matches
  always @(miso) if (!selN) last = miso;
  assign miso = selN ? ~last : txByte[lsb ? outIdx : ~outIdx];
endmodule

// [ssp_core_bench.sv]
// Self-checking bench for the serial port core
module ssp_core_bench
  import ssp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk, resetn, regWr, regRd, globalIrqEn, irqAck;
  logic [1:0] regAddr;
  logic [7:0] regWrData, regRdData, slvTx, slvRx, tx, ctl;
  logic       dirMosi, dirMiso, dirSck, dirSel, gpioMosi, gpioSel;
  logic       mosiOut, mosiDriveN, misoOut, misoDriveN, sckOut, sckDriveN;
  logic       selOut, selDriveN, extSck, extMosi, extSel, slvMiso;
  logic       sckPrev, gapErr, xferIrq;
  wire logic  mosiIn, misoIn, sckIn, selIn;
  int         n_errors, checked, edges, half, cyc, lastEdge, seed;
  // Pin levels from whichever side drives
  assign mosiIn = mosiDriveN ? extMosi : mosiOut;
  assign misoIn = misoDriveN ? slvMiso : misoOut;
  assign sckIn  = sckDriveN ? extSck : sckOut;
  assign selIn  = selDriveN ? extSel : selOut;
  ssp_core ssp_core_i (.*, .gpioMiso(1'b0), .gpioSck(1'b0));
  ssp_slave_model ssp_slave_model_i (.sck(sckIn), .selN(selIn),
    .mosi(mosiIn), .clock_polarity(ctl[SSP_CTRL_CLOCK_POLARITY]), .clock_phase(ctl[SSP_CTRL_CLOCK_PHASE]),
    .lsb(ctl[SSP_CTRL_LSB_1ST]), .txByte(slvTx), .miso(slvMiso),
    .rxByte(slvRx));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // SCK edge count and spacing; first edge of a frame has no gap
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    sckPrev <= sckOut;
    if (sckOut !== sckPrev) begin
      if (edges > 0 && cyc - lastEdge != half)
        gapErr <= 1'b1;
      edges <= edges + 1;
      lastEdge <= cyc;
    end
  end
  function automatic int halfOf(input logic [2:0] r);
    int tab[8] = '{2, 8, 32, 64, 1, 4, 16, 32};  // Half SCK in clocks
    return tab[r];
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    chk(regRdData, exp);
    @(posedge sys_clk);
  endtask
  // External master in mode 0, phases of four clocks each
  task automatic ext(input logic [7:0] b, input int n, input logic s);
    extSel <= s;
    for (int k = 0; k < n; k++) begin
      extMosi <= b[7 - k];
      repeat (4) @(posedge sys_clk);
      extSck <= 1'b1;
      repeat (4) @(posedge sys_clk);
      extSck <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    extSel <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Watchdog well beyond the longest expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    seed = 32'h2EE7B79F;
    {regWr, regRd, irqAck, dirMiso, gpioMosi, extSck, extMosi} = '0;
    {dirMosi, dirSck, dirSel, gpioSel, extSel, globalIrqEn} = '1;
    {regAddr, regWrData, ctl, slvTx} = '0;
    resetn = 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rdc(SSP_OFS_CTRL, SSP_CTRL_RST);
    rdc(SSP_OFS_STATUS, 8'h00);
    rdc(SSP_OFS_DATA, SSP_DATA_RST);
    rdc(2'h3, 8'h00);
    // Every rate code once, each mode twice, random data and bit order
    for (int i = 0; i < 8; i++) begin
      tx = $random(seed);
      slvTx = $random(seed);
      gpioMosi <= 1'($random(seed));
      ctl = {2'b11, 1'($random(seed)), 1'b1, 2'(i), 2'(i)};
      half = halfOf(3'(i));
      wr(SSP_OFS_STATUS, {7'h00, 1'(i >> 2)});
      wr(SSP_OFS_CTRL, ctl);
      gpioSel <= 1'b0;
      repeat (4) @(posedge sys_clk);
      edges = 0;
      gapErr = 1'b0;
      wr(SSP_OFS_DATA, tx);
      if (i == 2)
        wr(SSP_OFS_DATA, ~tx);
      for (int t = 0; t < 3000 && xferIrq !== 1'b1; t++)
        @(posedge sys_clk);
      gpioSel <= 1'b1;
      chk({7'h00, xferIrq}, 8'h01);
      chk(8'(edges), 8'h10);
      chk({7'h00, gapErr}, 8'h00);
      chk({7'h00, sckOut}, {7'h00, ctl[SSP_CTRL_CLOCK_POLARITY]});
      chk(slvRx, tx);
      if (i[0]) begin
        @(posedge sys_clk);
        irqAck <= 1'b1;
        @(posedge sys_clk);
        irqAck <= 1'b0;
        rdc(SSP_OFS_STATUS, {7'h00, 1'(i >> 2)});
        rdc(SSP_OFS_DATA, slvTx);
      end else begin
        rdc(SSP_OFS_STATUS, {1'b1, i == 2, 5'h00, 1'(i >> 2)});
        rdc(SSP_OFS_DATA, slvTx);
        rdc(SSP_OFS_STATUS, {7'h00, 1'(i >> 2)});
      end
      $display("Master transfer %0d done", i);
    end
    // Select input pulled low while master
    dirSel <= 1'b0;
    wr(SSP_OFS_CTRL, 8'h50);
    extSel <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rdc(SSP_OFS_CTRL, 8'h40);
    rdc(SSP_OFS_STATUS, 8'h81);
    extSel <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdc(SSP_OFS_CTRL, 8'h40);
    wr(SSP_OFS_DATA, 8'h00);
    $display("Forced slave test done");
    // Slave: deselected clocks, aborted byte, then a full byte
    wr(SSP_OFS_CTRL, 8'h40);
    dirMiso <= 1'b1;
    ext(8'hA5, 8, 1'b1);
    rdc(SSP_OFS_STATUS, 8'h01);
    ext(8'hFF, 3, 1'b0);
    tx = $random(seed);
    ext(tx, 8, 1'b0);
    rdc(SSP_OFS_STATUS, 8'h81);
    rdc(SSP_OFS_DATA, tx);
    $display("Slave test done");
    end_of_test();
  end
endmodule
